// >>> inc/ilm_pkg.sv
package ilm_pkg;

  // ***************
  // Register layout
  // ***************
  localparam int IlmWidth = 8;
  localparam int BitLevel7 = 7;
  localparam int BitLevel6 = 6;
  localparam int BitLevel5 = 5;
  localparam int BitLevel4 = 4;
  localparam logic [IlmWidth-1:0] IlmResetVal = 8'h00;
  localparam logic [IlmWidth-1:0] IlmLevelBits = 8'hf0;

  // ***************
  // Operand addressing forms
  // ***************
  typedef enum logic [3:0] {
    ADDR_REGISTER = 4'h1,
    ADDR_INDIRECT = 4'h2,
    ADDR_INDEXED = 4'h4,
    ADDR_DIRECT = 4'h8
  } ilm_addr_mode_t;

  // ***************
  // Access state
  // ***************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ACCESS = 2'h2
  } ilm_state_t;

  function automatic logic ilmSelected(input logic sel, input ilm_addr_mode_t mode);
    ilmSelected = sel && (mode == ADDR_REGISTER);
  endfunction : ilmSelected

endpackage : ilm_pkg

// >>> inc/ilm_req_if.sv
`timescale 1ns/1ps
interface ilm_req_if;
  import ilm_pkg::*;
  logic [IlmWidth-1:0] raw;
  logic [IlmWidth-1:0] mask;
  logic [IlmWidth-1:0] gated;
  modport gate (input raw, input mask, output gated);
  modport user (output raw, output mask, input gated);
endinterface : ilm_req_if

// >>> src/ilm_gate.sv
`timescale 1ns/1ps
module ilm_gate
  import ilm_pkg::*;
(
  ilm_req_if.gate bus // Raw requests and mask in, gated out
);
  // Only the four level bits carry sources
  assign bus.gated = bus.raw & bus.mask & IlmLevelBits; // see R6
endmodule : ilm_gate

// >>> src/ilm_top.sv
// Function
// R1: Bit 7 gates level seven, port 4 pins 0-3; 0 masks, 1 unmasks.
// R2: Bit 6 gates level six, port 4 pins 4-7; 0 masks, 1 unmasks.
// R3: Bit 5 gates level five, port 2 pins 4-7; 0 masks, 1 unmasks.
// R4: Bit 4 gates level four from the watch timer; 0 masks, 1 unmasks.
// R5: Register reachable only by register-mode operand addressing.
// R6: Requests forwarded only while unmasked; bits read/write; reset value undefined.
`timescale 1ns/1ps
module ilm_top
  import ilm_pkg::*;
(
  input wire logic clock, // 25 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic regSel, // Core selects this register
  input wire ilm_addr_mode_t addrMode, // Operand addressing form
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [IlmWidth-1:0] regWdata, // Write data
  output logic [IlmWidth-1:0] regRdata_r, // Read data
  output logic regRvalid_r, // Read data valid pulse
  input wire logic level_seven_request, // Port 4 pins 0-3
  input wire logic level_six_request, // Port 4 pins 4-7
  input wire logic level_five_request, // Port 2 pins 4-7
  input wire logic level_four_request, // Watch timer
  output logic [IlmWidth-1:0] maskOut_r, // Mask register value
  output logic [IlmWidth-1:0] coreRequest_r // Gated requests to core
);

  // ***************
  // Mask register
  // ***************
  logic [IlmWidth-1:0] mask_r;
  logic hit;
  ilm_state_t state_r;

  assign hit = ilmSelected(regSel, addrMode); // see R5

  // Reset value is undefined; zero is used so nothing fires early
  always_ff @(posedge clock) begin
    if (srst) begin
      mask_r <= IlmResetVal; // see R6
    end else if (hit && regWr) begin
      mask_r <= regWdata; // see R6
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (hit && (regWr || regRd)) begin
            state_r <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          state_r <= (hit && (regWr || regRd)) ? ST_ACCESS : ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      regRdata_r <= IlmResetVal;
      regRvalid_r <= 1'b0;
    end else begin
      regRvalid_r <= hit && regRd; // see R5
      if (hit && regRd) begin
        regRdata_r <= mask_r; // see R6
      end
    end
  end

  // ***************
  // Request gating
  // ***************
  ilm_req_if req ();
  ilm_gate u_gate (
    .bus(req.gate)
  );

  always_comb begin
    req.raw = IlmResetVal;
    req.raw[BitLevel7] = level_seven_request; // see R1
    req.raw[BitLevel6] = level_six_request; // see R2
    req.raw[BitLevel5] = level_five_request; // see R3
    req.raw[BitLevel4] = level_four_request; // see R4
    req.mask = mask_r;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      coreRequest_r <= IlmResetVal;
      maskOut_r <= IlmResetVal;
    end else begin
      coreRequest_r <= req.gated; // see R1 R2 R3 R4 R6
      maskOut_r <= mask_r;
    end
  end

endmodule : ilm_top

// >>> dv/ilm_core_model.sv
`timescale 1ns/1ps
module ilm_core_model (
  input wire logic clock, // Clock
  input wire logic [3:0] reqIn, // Wanted levels 7..4
  output logic [3:0] lvl // Request lines
);
  // Sources move only on edges, as port logic does
  always_ff @(posedge clock) lvl <= reqIn;
endmodule : ilm_core_model

// >>> dv/ilm_chk_sva.sv
`timescale 1ns/1ps
module ilm_chk
  import ilm_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic srst, // Reset
  input wire logic regSel, // Select
  input wire ilm_addr_mode_t addrMode, // Form
  input wire logic regWr, // Write
  input wire logic regRd, // Read
  input wire logic [7:0] regWdata, // Data
  input wire logic regRvalid_r, // Valid
  input wire logic [7:0] regRdata_r, // Read data
  input wire logic level_seven_request, // Level seven source
  input wire logic level_six_request, // Level six source
  input wire logic level_five_request, // Level five source
  input wire logic level_four_request, // Level four source
  input wire logic [7:0] maskOut_r, // Mask
  input wire logic [7:0] coreRequest_r // Gated
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire sel = regSel && addrMode == ADDR_REGISTER;
  mask_gate_a: assert property (!(coreRequest_r & ~maskOut_r)) else $error("g");
  low_zero_a: assert property (coreRequest_r[3:0] == 4'h0) else $error("z");
  rd_valid_a: assert property (sel && regRd |=> regRvalid_r) else $error("v");
  rd_mode_a: assert property (!(sel && regRd) |=> !regRvalid_r) else $error("r");
  wr_take_a: assert property (sel && regWr |=> ##1 maskOut_r == $past(regWdata, 2))
    else $error("w");
  wr_mode_a: assert property (!(sel && regWr) |=> ##1 $stable(maskOut_r))
    else $error("m");
  // Mask copy lags the live mask by one edge, as the gated word does
  seven_pass_a: assert property
    (coreRequest_r[7] == ($past(level_seven_request) && maskOut_r[7])) else $error("7");
  six_pass_a: assert property
    (coreRequest_r[6] == ($past(level_six_request) && maskOut_r[6])) else $error("6");
  five_pass_a: assert property
    (coreRequest_r[5] == ($past(level_five_request) && maskOut_r[5])) else $error("5");
  four_pass_a: assert property
    (coreRequest_r[4] == ($past(level_four_request) && maskOut_r[4])) else $error("4");
  rd_data_a: assert property (sel && regRd |=> regRdata_r == maskOut_r) else $error("d");
  cover property (sel && regWr);
  cover property (sel && regRd);
  cover property (|coreRequest_r);
endmodule : ilm_chk
bind ilm_top ilm_chk ilm_chk_inst (.*);

// >>> dv/tb_interrupt_level_mask.sv
`timescale 1ns/1ps
module tb_interrupt_level_mask;
  import ilm_pkg::*;
  logic clock = 0, srst = 1, regSel = 0, regWr = 0, regRd = 0, regRvalid_r;
  ilm_addr_mode_t addrMode = ADDR_REGISTER;
  logic [7:0] regWdata = 8'h00, regRdata_r, maskOut_r, coreRequest_r;
  logic [3:0] reqIn = 4'h0, lvl;
  // Rows: mask, request levels, gated result
  logic [19:0] rows [3] = '{20'h5af50, 20'ha5fa0, 20'hf0990};
  int fail_count = 0, checks = 0;
  always #20 clock = ~clock;
  ilm_core_model ilm_core_model_inst (.*);
  ilm_top ilm_top_inst (.*, .level_seven_request(lvl[3]), .level_six_request(lvl[2]),
    .level_five_request(lvl[1]), .level_four_request(lvl[0]));
  task chk(input logic [16:0] s, e);
    checks++;
    fail_count += int'(s !== e);
    if (s !== e) $display("[FAIL] %0t %h %h", $time, s, e);
  endtask : chk
  task results();
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task acc(input logic s, input ilm_addr_mode_t m, input logic w, input logic [7:0] d);
    @(posedge clock) {regSel, addrMode, regWr, regRd, regWdata} <= {s, m, w, !w, d};
    @(posedge clock) {regSel, regWr, regRd} <= 3'h0;
    #1;
  endtask : acc
  initial begin
    repeat (4) @(posedge clock);
    srst <= 0;
    #1 chk({9'h000, maskOut_r}, 17'h00000);
    foreach (rows[i]) begin
      acc(1, ADDR_REGISTER, 1, rows[i][19:12]);
      @(posedge clock) reqIn <= rows[i][11:8];
      acc(1, ADDR_REGISTER, 0, 8'h00);
      chk({regRvalid_r, regRdata_r, coreRequest_r}, {1'b1, rows[i][19:12], rows[i][7:0]});
    end
    // Three wrong forms, then a deselected write
    for (int i = 1; i < 5; i++) acc(i < 4, ilm_addr_mode_t'(4'h1 << i[1:0]), 1, 8'h5a);
    @(posedge clock) #1 chk({9'h000, maskOut_r}, 17'h000f0);
    // Mid-run reset with requests still raised
    @(posedge clock) srst <= 1;
    @(posedge clock) srst <= 0;
    #1 chk({regRvalid_r, regRdata_r, coreRequest_r}, 17'h00000);
    @(posedge clock) #1 chk({1'b0, maskOut_r, coreRequest_r}, 17'h00000);
    results();
  end
endmodule : tb_interrupt_level_mask
